// ### include/cht_pkg.sv
// shared constants and types for the codec host transfer counter
package cht_pkg;
  // clocking and sample period
  localparam int unsigned CLK_HZ      = 125000000;
  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned SAMPLE_HZ   = 48000;
  localparam int unsigned SAMPLE_CYC  = CLK_HZ / SAMPLE_HZ;
  localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);
  // direct addresses on the byte port
  localparam logic [1:0] ADR_INDEX  = 2'h0;
  localparam logic [1:0] ADR_IDATA  = 2'h1;
  localparam logic [1:0] ADR_STATUS = 2'h2;
  localparam logic [1:0] ADR_PIO    = 2'h3;
  // indexed registers
  localparam logic [3:0] IDX_IFCFG   = 4'h9;
  localparam logic [3:0] IDX_PINCTL  = 4'ha;
  localparam logic [3:0] IDX_MIX     = 4'hd;
  localparam logic [3:0] IDX_BASE_HI = 4'he;
  localparam logic [3:0] IDX_BASE_LO = 4'hf;
  localparam logic [7:0] IDX_RESET   = 8'h00;
  // field positions
  localparam int B_PEN  = 0;  // interface config
  localparam int B_CEN  = 1;
  localparam int B_PLAYBACK_SW_TRANSFER = 6;
  localparam int B_CAPTURE_SW_TRANSFER = 7;
  localparam int B_IEN  = 1;  // pin control
  localparam int B_TRD  = 2;
  localparam int B_XLO  = 6;
  localparam int B_MIXE = 0;  // mix control
  localparam int B_ATLO = 2;
  localparam int S_INT  = 0;  // status
  localparam int S_PLAYBACK_READY_FLAG = 1;
  localparam int S_PUR  = 4;
  localparam int S_CAPTURE_READY_FLAG = 5;
  localparam int S_COR  = 6;
  // attenuation: four 1.5 dB fractions in Q8, then 6 dB shifts
  localparam int ATT_Q = 8;
  localparam logic [8:0] ATT_FRAC [4] = '{9'h100, 9'h0d7, 9'h0b5, 9'h098};
  localparam logic signed [16:0] SAT_MAX = 17'sh07fff;
  localparam logic signed [16:0] SAT_MIN = -17'sh08000;
  // host strobe timing
  localparam int unsigned SETUP_NS  = 16;
  localparam int unsigned STROBE_NS = 80;
  localparam int unsigned RECOV_NS  = 40;
  localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RECOV_CYC  = 4'((RECOV_NS * CLK_MHZ + 999) / 1000);
  // host side AHB register map
  localparam logic [7:0] HOST_CMD_OFF  = 8'h00;
  localparam logic [7:0] HOST_STAT_OFF = 8'h04;
  localparam int C_ADR_LO = 8;
  localparam int C_READ   = 16;
  localparam int T_BUSY   = 0;
  localparam int T_RD_LO  = 8;
  localparam int T_IRQ    = 16;
  localparam int T_XC_LO  = 17;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RECOV} cht_host_e;
endpackage

// ### include/cht_if.sv
// byte-wide host port joining the host end and the codec end
`timescale 1ns/10ps
interface cht_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [1:0] adr;
  logic [7:0] hdata;
  logic       hdata_oe;
  logic [7:0] ddata;
  logic       ddata_oe;
  logic       capture_ack_n;
  logic       playback_ack_n;
  logic       irq;
  logic [1:0] ext_ctrl_out;
  logic [7:0] data_bus;

  // resolved data lines, floating bus reads as all ones
  assign data_bus = ddata_oe ? ddata : (hdata_oe ? hdata : 8'hff);

  modport host (output cs_n, rd_n, wr_n, adr, hdata, hdata_oe,
                capture_ack_n, playback_ack_n,
                input data_bus, irq, ext_ctrl_out);
  modport codec (input cs_n, rd_n, wr_n, adr, data_bus,
                 capture_ack_n, playback_ack_n,
                 output ddata, ddata_oe, irq, ext_ctrl_out);
endinterface // cht_if

// ### hw/cht_codec.sv
// codec end: byte port registers, sample counter, pio data and mix
// Behaviour
// - mix enable adds attenuated adc into dac
// - capture overrun keeps last captured sample
// - playback underrun gives midscale zero
// - six-bit attenuation in 1.5 dB steps
// - upper base write loads current counter
// - count down, then interrupt and reload
// - status write clears interrupt unless underflow in same cycle
// - irq pin high on underflow if enabled
// - decrement needs enable and not inhibited
// - status bit sets even with pin disabled
// - same counting for pio and dma
// - base bytes read back, counter unreadable
// - low byte first, then high byte
// - left channel bytes before right
// - host keeps pace with one-sample buffers
// - registers only by chip-selected cycles
// - pio active only with enable and select
// - host holds acks high during pio
// - drive data while read strobe low
// - write byte taken at strobe rising edge
// - host polls ready flags
// - external control pins follow within period
// - irq pin enable gates the pin
`timescale 1ns/10ps
module cht_codec
  import cht_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  cht_if.codec                    link,
  input  wire logic signed [15:0] adc_left,
  input  wire logic signed [15:0] adc_right,
  output logic signed [15:0]      dac_left,
  output logic signed [15:0]      dac_right,
  output logic                    sample_tick
);

  logic [14:0]       s1_r;
  logic [14:0]       s2_r;
  logic              rd_n_d_r;
  logic              wr_n_d_r;
  logic [10:0]       wlat_r;
  logic              rlat_r;
  logic [1:0]        radr_r;
  logic [7:0]        idx_r [16];
  logic [3:0]        index_r;
  logic [11:0]       div_r;
  logic              tick_r;
  logic [15:0]       cur_r;
  logic              int_r;
  logic              irq_r;
  logic [1:0]        xctl_r;
  logic [7:0]        dout_r;
  logic              doe_r;
  logic [7:0]        pb_buf_r [4];
  logic [1:0]        pb_cnt_r;
  logic              pb_full_r;
  logic              pur_r;
  logic signed [15:0] pb_l_r;
  logic signed [15:0] pb_r_r;
  logic [1:0]        cap_cnt_r;
  logic              cap_full_r;
  logic              cor_r;
  logic signed [15:0] cap_l_r;
  logic signed [15:0] cap_r_r;
  logic signed [15:0] dac_l_r;
  logic signed [15:0] dac_r_r;

  logic       cs_n_s, rd_n_s, wr_n_s, cak_s, pak_s, host_sel;
  logic [1:0] adr_s;
  logic [7:0] din_s, wd, stat, rmux;
  logic       wr_go, rd_done, play_on, cap_on, play_pio, cap_pio;
  logic       count_en, stat_wr, base_load;
  logic [7:0] ifcfg, pinctl, mixc;
  logic signed [15:0] mix_l, mix_r;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r     <= 15'h7fff;
      s2_r     <= 15'h7fff;
      rd_n_d_r <= 1'b1;
      wr_n_d_r <= 1'b1;
    end else begin
      s1_r     <= {link.cs_n, link.rd_n, link.wr_n, link.capture_ack_n,
                   link.playback_ack_n, link.adr, link.data_bus};
      s2_r     <= s1_r;
      rd_n_d_r <= rd_n_s;
      wr_n_d_r <= wr_n_s;
    end
  end

  assign {cs_n_s, rd_n_s, wr_n_s, cak_s, pak_s, adr_s, din_s} = s2_r;
  assign host_sel = !cs_n_s && cak_s && pak_s;
  assign ifcfg    = idx_r[IDX_IFCFG];
  assign pinctl   = idx_r[IDX_PINCTL];
  assign mixc     = idx_r[IDX_MIX];
  assign play_on  = ifcfg[B_PEN];
  assign cap_on   = ifcfg[B_CEN];
  assign play_pio = play_on && ifcfg[B_PLAYBACK_SW_TRANSFER];
  assign cap_pio  = cap_on && ifcfg[B_CAPTURE_SW_TRANSFER];

  // write cycle latched while strobe low, acted on at its rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wlat_r <= 11'h000;
      rlat_r <= 1'b0;
      radr_r <= ADR_INDEX;
    end else begin
      if (!wr_n_s)
        wlat_r <= {host_sel, adr_s, din_s};
      if (!rd_n_s) begin
        rlat_r <= host_sel;
        radr_r <= adr_s;
      end
    end
  end

  assign wd        = wlat_r[7:0];
  assign wr_go     = wr_n_s && !wr_n_d_r && wlat_r[10];
  assign rd_done   = rd_n_s && !rd_n_d_r && rlat_r;
  assign stat_wr   = wr_go && wlat_r[9:8] == ADR_STATUS;
  assign base_load = wr_go && wlat_r[9:8] == ADR_IDATA
                     && index_r == IDX_BASE_HI;

  ////////////////////////////////////////////////////////////////////
  // index register and indexed control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      index_r <= IDX_BASE_HI ^ IDX_BASE_HI;
      for (int i = 0; i < 16; i++)
        idx_r[i] <= IDX_RESET;
    end else if (wr_go) begin
      if (wlat_r[9:8] == ADR_INDEX)
        index_r <= wd[3:0];
      if (wlat_r[9:8] == ADR_IDATA)
        idx_r[index_r] <= wd;  // base bytes stored as written
    end
  end

  // sample period tick, sole enable of sample-rate logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r  <= 12'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r == SAMPLE_LAST;
      div_r  <= (div_r == SAMPLE_LAST) ? 12'h000 : div_r + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // current counter, interrupt status and pins
  assign count_en = (play_on || cap_on)
                    && (!pinctl[B_TRD] || !int_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_r <= 16'h0000;
    end else if (base_load) begin
      cur_r <= {wd, idx_r[IDX_BASE_LO]};
    end else if (tick_r && count_en) begin
      if (cur_r == 16'h0000)
        cur_r <= {idx_r[IDX_BASE_HI], idx_r[IDX_BASE_LO]};
      else
        cur_r <= cur_r - 16'h0001;
    end
  end

  // status bit: underflow sets it regardless of pin enable; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      int_r <= 1'b0;
    else if (tick_r && count_en && cur_r == 16'h0000)
      int_r <= 1'b1;
    else if (stat_wr)
      int_r <= 1'b0;
  end

  // irq pin follows status when enabled, control pins on the tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r  <= 1'b0;
      xctl_r <= 2'h0;
    end else begin
      irq_r <= int_r && pinctl[B_IEN];
      if (tick_r)
        xctl_r <= pinctl[B_XLO+1:B_XLO];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // playback pio: bytes L lo, L hi, R lo, R hi
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pb_cnt_r  <= 2'h0;
      pb_full_r <= 1'b0;
      pur_r     <= 1'b0;
      pb_l_r    <= 16'sh0000;
      pb_r_r    <= 16'sh0000;
      for (int i = 0; i < 4; i++)
        pb_buf_r[i] <= 8'h00;
    end else begin
      if (tick_r && play_on) begin
        if (pb_full_r) begin
          pb_l_r    <= {pb_buf_r[1], pb_buf_r[0]};
          pb_r_r    <= {pb_buf_r[3], pb_buf_r[2]};
          pb_full_r <= 1'b0;
          pur_r     <= 1'b0;
        end else begin
          pb_l_r <= 16'sh0000;
          pb_r_r <= 16'sh0000;
          pur_r  <= 1'b1;
        end
      end
      if (wr_go && wlat_r[9:8] == ADR_PIO && play_pio) begin
        pb_buf_r[pb_cnt_r] <= wd;
        pb_cnt_r           <= pb_cnt_r + 2'h1;
        if (pb_cnt_r == 2'h3)
          pb_full_r <= 1'b1;
      end
    end
  end

  // capture: one buffered sample, overrun keeps the older one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_cnt_r  <= 2'h0;
      cap_full_r <= 1'b0;
      cor_r      <= 1'b0;
      cap_l_r    <= 16'sh0000;
      cap_r_r    <= 16'sh0000;
    end else begin
      if (rd_done && radr_r == ADR_PIO && cap_pio) begin
        cap_cnt_r <= cap_cnt_r + 2'h1;
        if (cap_cnt_r == 2'h3)
          cap_full_r <= 1'b0;
      end
      if (tick_r) begin
        if (cap_on && cap_full_r) begin
          cor_r <= 1'b1;
        end else begin
          cap_l_r    <= adc_left;
          cap_r_r    <= adc_right;
          cap_full_r <= cap_on;
          cor_r      <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mix: attenuated capture plus playback, saturated
  function automatic logic signed [15:0] mix_add(
    input logic signed [15:0] adc,
    input logic signed [15:0] play,
    input logic [7:0]         ctl
  );
    logic signed [25:0] prod;
    logic signed [16:0] sum;
    prod = adc * $signed({1'b0, ATT_FRAC[ctl[B_ATLO+1:B_ATLO]]});
    prod = prod >>> (ATT_Q + int'(ctl[7:B_ATLO+2]));
    if (!ctl[B_MIXE])
      prod = 26'sh0;
    sum = 17'(prod) + 17'(play);
    if (sum > SAT_MAX)
      sum = SAT_MAX;
    else if (sum < SAT_MIN)
      sum = SAT_MIN;
    mix_add = sum[15:0];
  endfunction

  assign mix_l = mix_add(cap_l_r, play_on ? pb_l_r : 16'sh0000, mixc);
  assign mix_r = mix_add(cap_r_r, play_on ? pb_r_r : 16'sh0000, mixc);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_l_r <= 16'sh0000;
      dac_r_r <= 16'sh0000;
    end else if (tick_r) begin
      dac_l_r <= mix_l;
      dac_r_r <= mix_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data: driven while read strobe low on a selected cycle
  assign stat = {1'b0, cor_r, cap_pio && cap_full_r, pur_r, 2'h0,
                 play_pio && !pb_full_r, int_r};
  always_comb begin
    unique case (adr_s)
      ADR_INDEX:  rmux = {4'h0, index_r};
      ADR_IDATA:  rmux = idx_r[index_r];
      ADR_STATUS: rmux = stat;
      ADR_PIO: begin
        unique case (cap_cnt_r)
          2'h0:    rmux = cap_l_r[7:0];
          2'h1:    rmux = cap_l_r[15:8];
          2'h2:    rmux = cap_r_r[7:0];
          2'h3:    rmux = cap_r_r[15:8];
        endcase
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      doe_r  <= 1'b0;
      dout_r <= 8'h00;
    end else begin
      doe_r  <= !rd_n_s && host_sel;
      dout_r <= rmux;
    end
  end

  assign link.ddata        = dout_r;
  assign link.ddata_oe     = doe_r;
  assign link.irq          = irq_r;
  assign link.ext_ctrl_out = xctl_r;
  assign dac_left          = dac_l_r;
  assign dac_right         = dac_r_r;
  assign sample_tick       = tick_r;

endmodule // cht_codec

// ### hw/cht_host.sv
// host end: AHB-Lite command registers driving the byte port strobes
`timescale 1ns/10ps
module cht_host
  import cht_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  cht_if.host              link
);

  cht_host_e   st_r;
  logic [3:0]  tmr_r;
  logic        ap_wr_r;
  logic [7:0]  ap_adr_r;
  logic [31:0] hrdata_r;
  logic [10:0] s1_r;
  logic [10:0] s2_r;
  logic [7:0]  rbyte_r;
  logic        cs_n_r, rd_n_r, wr_n_r, oe_r, read_r;
  logic [1:0]  adr_r;
  logic [7:0]  wdat_r;
  logic        ap_go, start;
  logic [31:0] stat;

  // address phase capture, zero wait states
  assign ap_go = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r  <= 1'b0;
      ap_adr_r <= HOST_CMD_OFF;
      hrdata_r <= 32'h0000_0000;
    end else begin
      ap_wr_r <= ap_go && hwrite;
      if (ap_go) begin
        ap_adr_r <= haddr[7:0];
        hrdata_r <= (haddr[7:0] == HOST_STAT_OFF && !hwrite) ? stat
                    : 32'h0000_0000;
      end
    end
  end

  // status word: ext control 18:17, irq 16, last byte 15:8, busy 0
  assign stat = {13'h0000, s2_r[1:0], s2_r[2], rbyte_r,
                 7'h00, st_r != H_IDLE};
  assign start = ap_wr_r && ap_adr_r == HOST_CMD_OFF && st_r == H_IDLE;

  ////////////////////////////////////////////////////////////////////
  // pin inputs through two flops: {data, irq, ext control}
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 11'h000;
      s2_r <= 11'h000;
    end else begin
      s1_r <= {link.data_bus, link.irq, link.ext_ctrl_out};
      s2_r <= s1_r;
    end
  end

  // one byte cycle: setup, strobe low, recovery
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r    <= H_IDLE;
      tmr_r   <= 4'h0;
      cs_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      wr_n_r  <= 1'b1;
      oe_r    <= 1'b0;
      read_r  <= 1'b0;
      adr_r   <= ADR_INDEX;
      wdat_r  <= 8'h00;
      rbyte_r <= 8'h00;
    end else begin
      unique case (st_r)
        H_IDLE: if (start) begin
          st_r   <= H_SETUP;
          tmr_r  <= SETUP_CYC;
          cs_n_r <= 1'b0;
          read_r <= hwdata[C_READ];
          adr_r  <= hwdata[C_ADR_LO+1:C_ADR_LO];
          wdat_r <= hwdata[7:0];
          oe_r   <= !hwdata[C_READ];
        end
        H_SETUP: if (tmr_r == 4'h1) begin
          st_r   <= H_STROBE;
          tmr_r  <= STROBE_CYC;
          rd_n_r <= !read_r;
          wr_n_r <= read_r;
        end else begin
          tmr_r <= tmr_r - 4'h1;
        end
        H_STROBE: if (tmr_r == 4'h1) begin
          st_r   <= H_RECOV;
          tmr_r  <= RECOV_CYC;
          rd_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          if (read_r)
            rbyte_r <= s2_r[10:3];
        end else begin
          tmr_r <= tmr_r - 4'h1;
        end
        H_RECOV: if (tmr_r == 4'h1) begin
          st_r   <= H_IDLE;
          cs_n_r <= 1'b1;
          oe_r   <= 1'b0;
        end else begin
          tmr_r <= tmr_r - 4'h1;
        end
      endcase
    end
  end

  assign link.cs_n           = cs_n_r;
  assign link.rd_n           = rd_n_r;
  assign link.wr_n           = wr_n_r;
  assign link.adr            = adr_r;
  assign link.hdata          = wdat_r;
  assign link.hdata_oe       = oe_r;
  assign link.capture_ack_n  = 1'b1;  // acks held inactive
  assign link.playback_ack_n = 1'b1;
  assign hrdata              = hrdata_r;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;

endmodule // cht_host

// ### sim/cht_chk.sv
// checker on the byte port between the host end and the codec end
`timescale 1ns/10ps
module cht_chk
  import cht_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       hdata_oe,
  input wire logic       ddata_oe,
  input wire logic       capture_ack_n,
  input wire logic       playback_ack_n,
  input wire logic       irq,
  input wire logic [1:0] ext_ctrl_out
);
  logic [11:0] since_wr_r;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since a write strobe was last low, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      since_wr_r <= 12'hfff;
    else if (!wr_n)
      since_wr_r <= 12'h000;
    else if (since_wr_r != 12'hfff)
      since_wr_r <= since_wr_r + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // port cycle shape
  acks_idle_a: assert property (capture_ack_n && playback_ack_n)
    else $error("dma acknowledge active during host cycles");
  strobe_select_a: assert property ((!rd_n || !wr_n) |-> !cs_n)
    else $error("strobe without chip select");
  write_drive_a: assert property (!wr_n |-> hdata_oe)
    else $error("write strobe low with data not driven");
  write_width_a: assert property ($fell(wr_n) |-> !wr_n [*4])
    else $error("write strobe too short");
  read_drive_a: assert property ($fell(rd_n) |-> ##[1:5] ddata_oe)
    else $error("codec did not drive read data");
  read_hold_a: assert property ($rose(ddata_oe) |-> !rd_n [*4])
    else $error("read data driven outside read strobe");
  read_release_a: assert property ($rose(rd_n) |-> ##[1:5] !ddata_oe)
    else $error("codec kept driving after read strobe");
  no_contention_a: assert property (!(ddata_oe && hdata_oe))
    else $error("both ends drive the data lines");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin and control pins follow host writes
  irq_clear_a: assert property ($fell(irq) |-> since_wr_r < 12'h00a)
    else $error("interrupt pin fell without a host write");
  ext_follow_a: assert property ($changed(ext_ctrl_out) |->
    since_wr_r <= 12'ha3c)
    else $error("control pins changed late or without a write");
endmodule // cht_chk

// ### sim/codec_host_transfer_counter_test.sv
// self-checking bench joining host end and codec end over the byte port
`timescale 1ns/10ps
module codec_host_transfer_counter_test;
  import cht_pkg::*;
  typedef struct packed {
    logic [1:0]  k;
    logic [31:0] v;
    logic [31:0] m;
  } cht_note_s;
  logic               hclk, hresetn, hsel, hwrite, look, hreadyout, hresp;
  logic               sample_tick;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, seen, s;
  logic signed [15:0] adc_left, adc_right, dac_left, dac_right;
  cht_note_s          notes[$];
  cht_note_s          nt;
  int                 err_count, check_count;

  cht_if link ();
  cht_host i_cht_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link));
  cht_codec i_cht_codec (.hclk(hclk), .hresetn(hresetn), .link(link),
    .adc_left(adc_left), .adc_right(adc_right), .dac_left(dac_left),
    .dac_right(dac_right), .sample_tick(sample_tick));
  cht_chk i_cht_chk (.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n),
    .rd_n(link.rd_n), .wr_n(link.wr_n), .hdata_oe(link.hdata_oe),
    .ddata_oe(link.ddata_oe), .capture_ack_n(link.capture_ack_n),
    .playback_ack_n(link.playback_ack_n), .irq(link.irq),
    .ext_ctrl_out(link.ext_ctrl_out));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and note keeping
  task automatic check(input logic [31:0] sv, input logic [31:0] ev);
    check_count++;
    if (sv !== ev) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic note(input logic [1:0] k, input logic [31:0] v,
                      input logic [31:0] m);
    notes.push_back('{k, v, m});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // bus and port cycles
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, input logic chk,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    look   <= chk;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    look   <= 1'b0;
    rd = hrdata;
  endtask
  task automatic port(input logic r, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [31:0] st;
    ahb(1'b1, HOST_CMD_OFF, {15'h0000, r, 6'h00, a, d}, 1'b0, st);
    @(posedge hclk);
    st = 32'h00000001;
    while (st[T_BUSY] !== 1'b0)
      ahb(1'b0, HOST_STAT_OFF, 32'h0, 1'b0, st);
    q = st[T_RD_LO +: 8];
  endtask
  task automatic wreg(input logic [3:0] i, input logic [7:0] v);
    logic [7:0] q;
    port(1'b0, ADR_INDEX, {4'h0, i}, q);
    port(1'b0, ADR_IDATA, v, q);
  endtask
  // port read, then the status word must show the byte
  task automatic rchk(input logic [1:0] a, input logic [7:0] e,
                      input logic [7:0] m);
    logic [7:0]  q;
    logic [31:0] st;
    port(1'b1, a, 8'h00, q);
    note(2'h0, {16'h0000, e & m, 8'h00}, {16'h0000, m, 8'h00});
    ahb(1'b0, HOST_STAT_OFF, 32'h0, 1'b1, st);
  endtask
  task automatic ichk(input logic [3:0] i, input logic [7:0] e,
                      input logic [7:0] m);
    logic [7:0] q;
    port(1'b0, ADR_INDEX, {4'h0, i}, q);
    rchk(ADR_IDATA, e, m);
  endtask
  task automatic stchk(input logic [31:0] e, input logic [31:0] m);
    note(2'h0, e, m);
    ahb(1'b0, HOST_STAT_OFF, 32'h0, 1'b1, s);
  endtask
  task automatic dchk(input logic [15:0] l, input logic [15:0] r);
    note(2'h1, {16'h0000, l}, 32'h0000ffff);
    note(2'h2, {16'h0000, r}, 32'h0000ffff);
    look <= 1'b1;
    repeat (2) @(posedge hclk);
    look <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge hclk);
      while (sample_tick !== 1'b1) @(posedge hclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor: oldest note against the output it names
  always @(posedge hclk) begin
    if (look === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      seen = (nt.k == 2'h0) ? hrdata : (nt.k == 2'h1) ?
             {16'h0000, dac_left} : {16'h0000, dac_right};
      check(seen & nt.m, nt.v);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (95000) @(posedge hclk);
    err_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0]  q, lo, hi, mx;
    logic [15:0] l, r, e;
    logic [7:0]  mt [5];
    int          n;
    mt = '{8'h00, 8'h01, 8'h11, 8'hfd, 8'h05};
    {hresetn, hsel, hwrite, look, htrans} = '0;
    {haddr, hwdata, adc_left, adc_right} = '0;
    hsize = 3'h2;
    void'($urandom(32'hf4ee6c62));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ichk(IDX_MIX, 8'h00, 8'hfd);
    ichk(IDX_BASE_HI, 8'h00, 8'hff);
    ichk(IDX_BASE_LO, 8'h00, 8'hff);
    lo = 8'($urandom);
    hi = 8'($urandom);
    mx = 8'($urandom) & 8'hfd;
    wreg(IDX_BASE_LO, lo);
    wreg(IDX_BASE_HI, hi);
    wreg(IDX_MIX, mx);
    ichk(IDX_BASE_LO, lo, 8'hff);
    ichk(IDX_BASE_HI, hi, 8'hff);
    ichk(IDX_MIX, mx, 8'hfd);
    stchk(32'h0, 32'h0);
    note(2'h0, 32'h0, 32'hffffffff);
    ahb(1'b0, 8'h08, 32'h0, 1'b1, s);
    // count down from two: underflow on the third tick
    wreg(IDX_PINCTL, 8'h82);
    wreg(IDX_BASE_LO, 8'h02);
    wreg(IDX_BASE_HI, 8'h00);
    wreg(IDX_IFCFG, 8'h01);
    n = 0;
    while (link.irq !== 1'b1 && n < 5) begin
      @(posedge hclk);
      if (sample_tick === 1'b1)
        n++;
    end
    check(32'(n), 32'h3);
    rchk(ADR_STATUS, 8'h01, 8'h01);
    stchk(32'h00050000, 32'h00070000);
    port(1'b0, ADR_STATUS, 8'($urandom), q);
    repeat (8) @(posedge hclk);
    stchk(32'h0, 32'h00010000);
    wreg(IDX_PINCTL, 8'h40);
    tick(4);
    rchk(ADR_STATUS, 8'h01, 8'h01);
    stchk(32'h00020000, 32'h00070000);
    // mix of held adc data into an underrunning playback path
    for (int i = 0; i < 5; i++) begin
      l = 16'($urandom) & 16'h7ffe;
      r = 16'($urandom) & 16'h7ffe;
      adc_left <= l;
      adc_right <= r;
      wreg(IDX_MIX, mt[i]);
      tick(2);
      repeat (3) @(posedge hclk);
      e = (i == 1) ? l : (i == 2) ? l >> 1 : 16'h0;
      if (i == 4)
        e = 16'((32'(l) * 32'hd7) >> 8);
      dchk(e, (i == 1) ? r : (i == 2) ? r >> 1 :
           (i == 4) ? 16'((32'(r) * 32'hd7) >> 8) : 16'h0);
    end
    // software playback: ignored without select, then low byte first
    wreg(IDX_MIX, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wreg(IDX_IFCFG, (p == 1) ? 8'h41 : 8'h01);
      l = 16'($urandom);
      r = 16'($urandom);
      tick(1);
      rchk(ADR_STATUS, (p == 1) ? 8'h02 : 8'h00, 8'h02);
      port(1'b0, ADR_PIO, l[7:0], q);
      port(1'b0, ADR_PIO, l[15:8], q);
      port(1'b0, ADR_PIO, r[7:0], q);
      port(1'b0, ADR_PIO, r[15:8], q);
      tick(2);  // sample taken, then played
      repeat (3) @(posedge hclk);
      dchk((p == 1) ? l : 16'h0, (p == 1) ? r : 16'h0);
    end
    tick(1);
    repeat (3) @(posedge hclk);
    dchk(16'h0, 16'h0);
    // capture overrun: the sample held before it keeps feeding the mix
    adc_left <= l;
    adc_right <= r;
    wreg(IDX_MIX, 8'h01);
    wreg(IDX_IFCFG, 8'h02);
    tick(1);
    adc_left <= ~l;
    adc_right <= ~r;
    tick(2);
    repeat (3) @(posedge hclk);
    dchk(l, r);
    complete_run();
  end
endmodule // codec_host_transfer_counter_test
